//--- psu_bus_sync.sv
// two-flop level synchroniser, parameterised width
`timescale 1ns/1ps

module psu_bus_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_q <= RST_VAL;
            o_q    <= RST_VAL;
        end
        else
        begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule

//--- psu_mgmt_bus_slave_front_end.sv
// constants and top module of the management-bus slave front end
// Behaviour
// - The slave runs at the standard 100 kbps bus rate; the host model clocks faster, with 7.5 us bits.
// - The slave avoids holding the clock low and stretches only where unavoidable.
// - Total clock stretching by the slave between START and STOP stays within 25 ms.
// - A clock held low for more than 25 ms makes the slave abort and release both lines.
// - After such an abort the slave accepts a new transaction within 10 ms.
// - START and STOP are recognised at any bit position, not only at byte boundaries.
// - Glitches and out-of-spec timing never lock the slave; it resumes on clean timing.
// - A missed clock is tolerated and the bit and byte state realign at START or STOP.
// - Two position straps n select control address 0xB0+2n and store address 0xA0+2n.
// - A 256 by 8 bit identification store is readable and writable over the bus.
// - Control-function bytes are handed to the command layer as bus transactions.
package psu_bus_pkg;
    localparam int          SYS_CLK_HZ      = 20_000_000;
    localparam int          BUS_RATE_KBPS   = 100;
    localparam int          TIMEOUT_MS      = 25;
    localparam int          RECOVER_MS      = 10;
    localparam int          TIMEOUT_CYC_DEF = TIMEOUT_MS * (SYS_CLK_HZ / 1000) + 1;
    localparam int          TMO_W           = 20;
    localparam logic [7:0]  CTL_ADDR_BASE   = 8'hb0;
    localparam logic [7:0]  FRU_ADDR_BASE   = 8'ha0;
    localparam int          FRU_DEPTH       = 256;
    localparam logic [1:0]  FILT_LEN        = 2'h3;
    localparam logic [3:0]  BYTE_BITS       = 4'h8;
    localparam logic [3:0]  FIRST_TX_BIT    = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_RACK = 3'b100
    } bus_state_t;
endpackage

`timescale 1ns/1ps

module psu_mgmt_bus_slave_front_end #(
    parameter int unsigned TIMEOUT_CYC = psu_bus_pkg::TIMEOUT_CYC_DEF
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_link_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_position_strap_low,
    input  wire logic       i_position_strap_high,
    input  wire logic [7:0] i_ctl_rd_byte,
    output logic            o_scl,
    output logic            o_scl_oe_n,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    output logic [7:0]      o_ctl_byte,
    output logic            o_ctl_byte_stb,
    output logic            o_ctl_cmd_first,
    output logic            o_bus_timeout
);

    localparam logic [psu_bus_pkg::TMO_W-1:0] TMO_LIM = TIMEOUT_CYC[psu_bus_pkg::TMO_W-1:0];

    // ---------------- link domain ----------------
    logic [1:0]              line_s;
    logic [1:0]              line_f_q;
    logic [1:0]              line_p_q;
    logic [1:0]              flt_cnt_q [2];
    logic [1:0]              strap_s;
    logic [1:0]              strap_q;
    logic                    strap_vld_q;
    logic                    strap_rdy_s;
    logic [7:0]              ctl_rd_s;
    logic                    abt_s;
    logic                    abt_seen_q;
    psu_bus_pkg::bus_state_t st_q;
    logic [3:0]              cnt_q;
    logic [7:0]              shreg_q;
    logic                    addr_phase_q;
    logic                    rw_q;
    logic                    fru_sel_q;
    logic                    ptr_set_q;
    logic [7:0]              ptr_q;
    logic [7:0]              fru_mem [psu_bus_pkg::FRU_DEPTH];
    logic                    ctl_tgl_q;
    logic [7:0]              ctl_byte_q;
    logic                    ctl_first_q;

    psu_bus_sync #(.W(2), .RST_VAL(2'h3)) u_line_sync (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_sda, i_scl}),
        .o_q     (line_s)
    );

    psu_bus_sync #(.W(2)) u_strap_sync (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_position_strap_high, i_position_strap_low}),
        .o_q     (strap_s)
    );

    // goes high once the strap synchroniser holds pin values, not its reset value
    psu_bus_sync #(.W(1)) u_strap_rdy (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_d     (1'b1),
        .o_q     (strap_rdy_s)
    );

    // read value from the command layer; it holds it steady across a byte
    psu_bus_sync #(.W(8)) u_rd_sync (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_ctl_rd_byte),
        .o_q     (ctl_rd_s)
    );

    // glitch filter: a line flips only after FILT_LEN agreeing samples
    // a few tens of ns is far below a 100 kbps bit, so real edges pass
    for (genvar g = 0; g < 2; g++)
    begin : g_filt
        always_ff @(posedge i_link_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
                flt_cnt_q[g] <= '0;
            else if (line_s[g] == line_f_q[g])
                flt_cnt_q[g] <= '0;
            else
                flt_cnt_q[g] <= flt_cnt_q[g] + 2'h1;
        end

        always_ff @(posedge i_link_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
                line_f_q[g] <= 1'b1;
            else if (line_s[g] != line_f_q[g] && flt_cnt_q[g] == psu_bus_pkg::FILT_LEN - 2'h1)
                line_f_q[g] <= line_s[g];
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            line_p_q <= 2'h3;
        else
            line_p_q <= line_f_q;
    end

    // straps caught once after reset, static afterwards
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            strap_q     <= '0;
            strap_vld_q <= 1'b0;
        end
        else if (!strap_vld_q && strap_rdy_s)
        begin
            strap_q     <= strap_s;
            strap_vld_q <= 1'b1;
        end
    end

    // line events and decode
    wire       scl_f      = line_f_q[0];
    wire       sda_f      = line_f_q[1];
    wire       scl_rise_w = scl_f & ~line_p_q[0];
    wire       scl_fall_w = ~scl_f & line_p_q[0];
    wire       start_w    = scl_f & line_p_q[0] & line_p_q[1] & ~sda_f;
    wire       stop_w     = scl_f & line_p_q[0] & ~line_p_q[1] & sda_f;
    wire       abort_evt  = abt_s ^ abt_seen_q;
    wire       ev_ok_w    = ~abort_evt & ~start_w & ~stop_w;
    wire [7:0] strap_off  = {5'h00, strap_q, 1'b0};
    wire [7:0] ctl_addr_w = psu_bus_pkg::CTL_ADDR_BASE + strap_off;
    wire [7:0] fru_addr_w = psu_bus_pkg::FRU_ADDR_BASE + strap_off;
    wire       ctl_hit_w  = strap_vld_q && shreg_q[7:1] == ctl_addr_w[7:1];
    wire       fru_hit_w  = strap_vld_q && shreg_q[7:1] == fru_addr_w[7:1];
    wire       byte_end_w = cnt_q == psu_bus_pkg::BYTE_BITS;
    wire       rx_done_w  = ev_ok_w && st_q == psu_bus_pkg::ST_RX && scl_fall_w && byte_end_w;
    wire       addr_ack_w = rx_done_w & addr_phase_q & (ctl_hit_w | fru_hit_w);
    wire       rx_data_w  = rx_done_w & ~addr_phase_q;
    wire       tx_load_w  = ev_ok_w && scl_fall_w &&
                            ((st_q == psu_bus_pkg::ST_ACK && rw_q) || st_q == psu_bus_pkg::ST_RACK);
    wire       fru_wr_w   = rx_data_w & fru_sel_q & ptr_set_q;
    wire       fru_ld_w   = rx_data_w & fru_sel_q & ~ptr_set_q;
    wire       ctl_rx_w   = rx_data_w & ~fru_sel_q;
    wire [7:0] tx_byte_w  = fru_sel_q ? fru_mem[ptr_q] : ctl_rd_s;

    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            abt_seen_q <= 1'b0;
        else
            abt_seen_q <= abt_s;
    end

    // protocol engine: abort, then START/STOP, override any bit position
    // the slave never holds SCL, so no stretch ever builds up
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q         <= psu_bus_pkg::ST_IDLE;
            cnt_q        <= '0;
            shreg_q      <= '0;
            addr_phase_q <= 1'b0;
            rw_q         <= 1'b0;
            fru_sel_q    <= 1'b0;
            o_sda_oe_n   <= 1'b1;
        end
        else if (abort_evt)
        begin
            st_q       <= psu_bus_pkg::ST_IDLE;
            o_sda_oe_n <= 1'b1;
        end
        else if (start_w)
        begin
            st_q         <= psu_bus_pkg::ST_RX;
            cnt_q        <= '0;
            addr_phase_q <= 1'b1;
            o_sda_oe_n   <= 1'b1;
        end
        else if (stop_w)
        begin
            st_q       <= psu_bus_pkg::ST_IDLE;
            o_sda_oe_n <= 1'b1;
        end
        else
        begin
            unique case (st_q)
                psu_bus_pkg::ST_IDLE:
                    o_sda_oe_n <= 1'b1;
                psu_bus_pkg::ST_RX:
                    if (scl_rise_w && !byte_end_w)
                    begin
                        shreg_q <= {shreg_q[6:0], sda_f};
                        cnt_q   <= cnt_q + 4'h1;
                    end
                    else if (rx_done_w && addr_phase_q && !addr_ack_w)
                        st_q <= psu_bus_pkg::ST_IDLE; // not ours: stay off until START
                    else if (rx_done_w)
                    begin
                        cnt_q        <= '0;
                        o_sda_oe_n   <= 1'b0;
                        st_q         <= psu_bus_pkg::ST_ACK;
                        addr_phase_q <= 1'b0;
                        if (addr_phase_q)
                        begin
                            rw_q      <= shreg_q[0];
                            fru_sel_q <= fru_hit_w;
                        end
                    end
                psu_bus_pkg::ST_ACK:
                    if (tx_load_w)
                    begin
                        o_sda_oe_n <= tx_byte_w[7];
                        shreg_q    <= {tx_byte_w[6:0], 1'b0};
                        cnt_q      <= psu_bus_pkg::FIRST_TX_BIT;
                        st_q       <= psu_bus_pkg::ST_TX;
                    end
                    else if (scl_fall_w)
                    begin
                        o_sda_oe_n <= 1'b1;
                        st_q       <= psu_bus_pkg::ST_RX;
                    end
                psu_bus_pkg::ST_TX:
                    if (scl_fall_w && byte_end_w)
                    begin
                        o_sda_oe_n <= 1'b1;
                        st_q       <= psu_bus_pkg::ST_RACK;
                    end
                    else if (scl_fall_w)
                    begin
                        o_sda_oe_n <= shreg_q[7];
                        shreg_q    <= {shreg_q[6:0], 1'b0};
                        cnt_q      <= cnt_q + 4'h1;
                    end
                psu_bus_pkg::ST_RACK:
                    if (scl_rise_w && sda_f)
                        st_q <= psu_bus_pkg::ST_IDLE; // master refused: read ends
                    else if (tx_load_w)
                    begin
                        o_sda_oe_n <= tx_byte_w[7];
                        shreg_q    <= {tx_byte_w[6:0], 1'b0};
                        cnt_q      <= psu_bus_pkg::FIRST_TX_BIT;
                        st_q       <= psu_bus_pkg::ST_TX;
                    end
                default:
                    st_q <= psu_bus_pkg::ST_IDLE;
            endcase
        end
    end

    // identification store: first written byte sets the pointer, which wraps
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ptr_q     <= '0;
            ptr_set_q <= 1'b0;
            for (int i = 0; i < psu_bus_pkg::FRU_DEPTH; i++)
                fru_mem[i] <= '0;
        end
        else
        begin
            if (addr_ack_w)
                ptr_set_q <= 1'b0;
            else if (rx_data_w)
                ptr_set_q <= 1'b1; // any first data byte, store or control
            if (fru_ld_w)
                ptr_q <= shreg_q;
            else if (fru_wr_w || (tx_load_w && fru_sel_q))
                ptr_q <= ptr_q + 8'h01;
            if (fru_wr_w)
                fru_mem[ptr_q] <= shreg_q;
        end
    end

    // control bytes leave by toggle; data stays put far longer than the crossing
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctl_tgl_q   <= 1'b0;
            ctl_byte_q  <= '0;
            ctl_first_q <= 1'b0;
        end
        else if (ctl_rx_w)
        begin
            ctl_tgl_q   <= ~ctl_tgl_q;
            ctl_byte_q  <= shreg_q;
            ctl_first_q <= ~ptr_set_q;
        end
    end

    // ctl writes reuse ptr_set_q as the command-code-seen marker
    // ---------------- system domain ----------------
    logic                   scl_s;
    logic                   ctl_tgl_s;
    logic                   ctl_seen_q;
    logic [psu_bus_pkg::TMO_W-1:0] lo_cnt_q;
    logic                   abort_tgl_q;

    psu_bus_sync #(.W(1), .RST_VAL(1'b1)) u_scl_sys_sync (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_scl),
        .o_q     (scl_s)
    );

    psu_bus_sync #(.W(1)) u_tgl_sync (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_d     (ctl_tgl_q),
        .o_q     (ctl_tgl_s)
    );

    psu_bus_sync #(.W(1)) u_abt_sync (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_d     (abort_tgl_q),
        .o_q     (abt_s)
    );

    wire tmo_hit_w = ~scl_s && lo_cnt_q == TMO_LIM - 1'b1;

    // clock-low timer; fires once per low period, a host keeping to spec never trips it
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            lo_cnt_q      <= '0;
            abort_tgl_q   <= 1'b0;
            o_bus_timeout <= 1'b0;
        end
        else
        begin
            o_bus_timeout <= tmo_hit_w;
            if (scl_s)
                lo_cnt_q <= '0;
            else if (lo_cnt_q != TMO_LIM)
                lo_cnt_q <= lo_cnt_q + 1'b1;
            if (tmo_hit_w)
                abort_tgl_q <= ~abort_tgl_q;
        end
    end

    // hand-off of control bytes to the command layer
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctl_seen_q      <= 1'b0;
            o_ctl_byte_stb  <= 1'b0;
            o_ctl_byte      <= '0;
            o_ctl_cmd_first <= 1'b0;
            o_scl           <= 1'b0;
            o_scl_oe_n      <= 1'b1;
            o_sda           <= 1'b0;
        end
        else
        begin
            ctl_seen_q     <= ctl_tgl_s;
            o_ctl_byte_stb <= ctl_tgl_s ^ ctl_seen_q;
            if (ctl_tgl_s ^ ctl_seen_q)
            begin
                o_ctl_byte      <= ctl_byte_q;
                o_ctl_cmd_first <= ctl_first_q;
            end
        end
    end

    // ---------------- checks ----------------
    a_start_realign: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        (start_w && !abort_evt) |=> st_q == psu_bus_pkg::ST_RX && cnt_q == 4'h0 && o_sda_oe_n)
        else $error("start did not realign engine");
    a_stop_release: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        stop_w |=> st_q == psu_bus_pkg::ST_IDLE && o_sda_oe_n)
        else $error("stop did not release bus");
    a_abort_idle: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        abort_evt |=> st_q == psu_bus_pkg::ST_IDLE && o_sda_oe_n)
        else $error("abort left bus driven");
    a_tmo_fire: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        tmo_hit_w |=> o_bus_timeout && abort_tgl_q != $past(abort_tgl_q)
            ##[1:8] abt_seen_q == abort_tgl_q)
        else $error("timeout not raised");
    a_no_stretch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_scl_oe_n)
        else $error("clock line driven");
    a_addr_ack: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        addr_ack_w |=> !o_sda_oe_n && st_q == psu_bus_pkg::ST_ACK ##1 !o_sda_oe_n)
        else $error("address match not acknowledged");
    a_strap_fixed: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        strap_vld_q |=> $stable(strap_q) && $stable(ctl_addr_w))
        else $error("strap value moved");
    a_filter_hold: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        $changed(line_f_q[0]) |->
            $past(line_s[0], 1) == line_f_q[0] && $past(line_s[0], 3) == line_f_q[0])
        else $error("clock filter passed a runt");
    a_fru_write: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        fru_wr_w |=> ptr_q == $past(ptr_q) + 8'h01 && fru_mem[$past(ptr_q)] == $past(shreg_q))
        else $error("store write lost");
    a_ctl_strobe: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
        ctl_rx_w |=> ##[1:16] o_ctl_byte_stb)
        else $error("control byte not handed over");

    c_fru_read: cover property (@(posedge i_link_clk) disable iff (!i_rst_n)
        tx_load_w && fru_sel_q);
    c_ctl_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_ctl_byte_stb && o_ctl_cmd_first);
    c_timeout: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_bus_timeout);
    c_mid_start: cover property (@(posedge i_link_clk) disable iff (!i_rst_n)
        start_w && st_q == psu_bus_pkg::ST_TX);

endmodule

//--- host_master_model.sv
// host master model that clocks the two-wire link with 7.5 us bits
`timescale 1ns/1ps

module host_master_model (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_oe_n,
    output logic      o_sda_oe_n
);
    // high phase and half the low phase of a 7.5 us bit, at 50 ns per step
    localparam int Q = 50;

    // both lines released: the pull-ups take them high
    initial
    begin
        o_scl_oe_n = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    task automatic wq(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // release the clock, wait out any stretch, then hold high
    task automatic hi();
        o_scl_oe_n = 1'b1;
        wait (i_scl === 1'b1);
        wq(Q);
    endtask

    // one bit: data moves mid-low, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic s);
        o_sda_oe_n = b;
        wq(Q);
        hi();
        s = i_sda;
        o_scl_oe_n = 1'b0;
        wq(Q);
    endtask

    // works from idle and as a repeated start
    task automatic start();
        o_sda_oe_n = 1'b1;
        wq(Q);
        hi();
        o_sda_oe_n = 1'b0;
        wq(Q);
        o_scl_oe_n = 1'b0;
        wq(Q);
    endtask

    task automatic stop();
        o_sda_oe_n = 1'b0;
        wq(Q);
        hi();
        o_sda_oe_n = 1'b1;
        wq(2 * Q);
    endtask

    // first n bits of d, msb first; a full byte also reads the ack
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--)
            bit_io(d[i], s);
        if (n == 8)
        begin
            bit_io(1'b1, s);
            ack = ~s;
        end
    endtask

    task automatic recv(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(nack, s);
    endtask

    // deliberately overlong clock low, only when a test asks for it
    task automatic hold_low(input int n);
        o_scl_oe_n = 1'b0;
        wq(n);
    endtask

    // runts far shorter than the slave's glitch filter
    task automatic runt_scl();
        o_scl_oe_n = ~o_scl_oe_n;
        #20;
        o_scl_oe_n = ~o_scl_oe_n;
    endtask

    task automatic runt_sda();
        o_sda_oe_n = ~o_sda_oe_n;
        #20;
        o_sda_oe_n = ~o_sda_oe_n;
    endtask
endmodule

//--- tb_top.sv
// self-checking bench for the management-bus slave front end
`timescale 1ns/1ps

module tb_top;
    // short clock-low limit; normal low phases last 100 cycles
    localparam int TMO = 400;

    logic       i_sys_clk  = 1'b0;
    logic       i_link_clk = 1'b0;
    logic       i_rst_n    = 1'b0;
    logic [1:0] strap      = 2'h0;
    logic [7:0] rd_byte    = 8'h00;
    logic       h_scl_oe_n, h_sda_oe_n, ack;
    logic       d_scl, d_scl_oe_n, d_sda, d_sda_oe_n, d_stb, d_first, d_tmo;
    logic [7:0] d_byte, rx;
    logic [8:0] stb_q[$];
    int         failures, checks_done, tmo_seen, stretch_seen;
    wire        scl_w, sda_w;

    // open-drain wires with pull-ups
    assign scl_w = h_scl_oe_n & (d_scl_oe_n | d_scl);
    assign sda_w = h_sda_oe_n & (d_sda_oe_n | d_sda);

    always #25 i_sys_clk = ~i_sys_clk;
    always #7.5 i_link_clk = ~i_link_clk;

    psu_mgmt_bus_slave_front_end #(
        .TIMEOUT_CYC(TMO)
    ) dut (
        .i_sys_clk            (i_sys_clk),
        .i_rst_n              (i_rst_n),
        .i_link_clk           (i_link_clk),
        .i_scl                (scl_w),
        .i_sda                (sda_w),
        .i_position_strap_low (strap[0]),
        .i_position_strap_high(strap[1]),
        .i_ctl_rd_byte        (rd_byte),
        .o_scl                (d_scl),
        .o_scl_oe_n           (d_scl_oe_n),
        .o_sda                (d_sda),
        .o_sda_oe_n           (d_sda_oe_n),
        .o_ctl_byte           (d_byte),
        .o_ctl_byte_stb       (d_stb),
        .o_ctl_cmd_first      (d_first),
        .o_bus_timeout        (d_tmo)
    );

    host_master_model host (
        .i_clk     (i_sys_clk),
        .i_scl     (scl_w),
        .i_sda     (sda_w),
        .o_scl_oe_n(h_scl_oe_n),
        .o_sda_oe_n(h_sda_oe_n)
    );

    // log hand-offs, timeout pulses and any clock stretching
    // sampled mid-cycle, away from the edge that launches them
    always @(negedge i_sys_clk)
    begin
        if (d_stb === 1'b1)
            stb_q.push_back({d_first, d_byte});
        if (d_tmo === 1'b1)
            tmo_seen++;
        if (d_scl_oe_n !== 1'b1)
            stretch_seen++;
    end

    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // about 56k cycles expected, so a hang is cut off at 95k
    initial
    begin
        repeat (95000) @(posedge i_sys_clk);
        failures++;
        summarize();
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s exp %h got %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] ctl(input logic [1:0] n);
        return psu_bus_pkg::CTL_ADDR_BASE + {5'h00, n, 1'b0};
    endfunction

    function automatic logic [7:0] fru(input logic [1:0] n);
        return psu_bus_pkg::FRU_ADDR_BASE + {5'h00, n, 1'b0};
    endfunction

    // straps change only together with a reset
    task automatic reset_dut(input logic [1:0] n);
        @(negedge i_sys_clk);
        i_rst_n = 1'b0;
        strap = n;
        repeat (6) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        repeat (10) @(negedge i_sys_clk);
    endtask

    task automatic addr_only(input logic [7:0] a, input logic exp);
        host.start();
        host.send(a, 8, ack);
        host.stop();
        chk("address ack", 16'(exp), 16'(ack));
    endtask

    task automatic sc_address();
        for (int n = 0; n < 4; n++)
        begin
            reset_dut(2'(n));
            addr_only(ctl(strap), 1'b1);
            addr_only(fru(strap), 1'b1);
            addr_only(ctl(strap + 2'h1), 1'b0);
        end
    endtask

    task automatic sc_ctl_write();
        stb_q = {};
        host.start();
        host.send(ctl(strap), 8, ack);
        host.send(8'h3b, 8, ack);
        host.send(8'h5a, 8, ack);
        host.stop();
        chk("data ack", 16'h0001, 16'(ack));
        chk("handoff count", 16'h0002, 16'(stb_q.size()));
        chk("command byte", 16'h013b, 16'(stb_q[0]));
        chk("data byte", 16'h005a, 16'(stb_q[1]));
    endtask

    // write across the top of the store, then read back through the wrap
    task automatic sc_fru();
        host.start();
        host.send(fru(strap), 8, ack);
        host.send(8'hff, 8, ack);
        host.send(8'h11, 8, ack);
        host.send(8'h22, 8, ack);
        host.start();
        host.send(fru(strap), 8, ack);
        host.send(8'hff, 8, ack);
        host.start();
        host.send(fru(strap) | 8'h01, 8, ack);
        host.recv(1'b0, rx);
        chk("store ff", 16'h0011, 16'(rx));
        host.recv(1'b1, rx);
        chk("store 00", 16'h0022, 16'(rx));
        host.stop();
    endtask

    task automatic sc_ctl_read();
        @(negedge i_sys_clk);
        rd_byte = 8'hc3;
        host.start();
        host.send(ctl(strap) | 8'h01, 8, ack);
        host.recv(1'b1, rx);
        host.stop();
        chk("control read", 16'h00c3, 16'(rx));
    endtask

    // runts, a torn byte, a mid-byte restart and a mid-byte stop
    task automatic sc_resync();
        stb_q = {};
        host.runt_scl();
        host.runt_sda();
        host.start();
        host.send(ctl(strap), 8, ack);
        host.send(8'h9c, 3, ack);
        host.runt_scl();
        host.send(8'h9c, 2, ack);
        host.start();
        host.send(ctl(strap), 8, ack);
        chk("ack after restart", 16'h0001, 16'(ack));
        host.send(8'h44, 8, ack);
        host.send(8'h77, 4, ack);
        host.stop();
        host.start();
        host.send(ctl(strap), 8, ack);
        host.send(8'h21, 8, ack);
        host.stop();
        chk("resync count", 16'h0002, 16'(stb_q.size()));
        chk("after restart", 16'h0144, 16'(stb_q[0]));
        chk("after stop", 16'h0121, 16'(stb_q[1]));
    endtask

    // clock held low while the slave drives a zero read bit
    task automatic sc_timeout();
        stb_q = {};
        tmo_seen = 0;
        @(negedge i_sys_clk);
        rd_byte = 8'h00;
        host.start();
        host.send(ctl(strap) | 8'h01, 8, ack);
        host.hold_low(TMO - 80);
        chk("no early timeout", 16'h0000, 16'(tmo_seen));
        chk("bit driven", 16'h0000, 16'(d_sda_oe_n));
        host.hold_low(80);
        chk("timeout pulse", 16'h0001, 16'(tmo_seen));
        chk("data freed", 16'h0001, 16'(d_sda_oe_n));
        host.hold_low(TMO);
        chk("one pulse per low", 16'h0001, 16'(tmo_seen));
        host.start();
        host.send(ctl(strap), 8, ack);
        chk("ack after abort", 16'h0001, 16'(ack));
        host.send(8'h5e, 8, ack);
        host.stop();
        chk("byte after abort", 16'h015e, 16'(stb_q[0]));
    endtask

    initial
    begin
        failures = 0;
        checks_done = 0;
        tmo_seen = 0;
        stretch_seen = 0;
        #100;
        chk("reset outputs", 16'hc000,
            {d_scl_oe_n, d_sda_oe_n, d_stb, d_tmo, d_first, d_scl, d_sda, 1'b0, d_byte});
        sc_address();
        sc_ctl_write();
        sc_fru();
        sc_ctl_read();
        sc_resync();
        sc_timeout();
        chk("clock stretch", 16'h0000, 16'(stretch_seen));
        summarize();
    end
endmodule
